// ==== sim/fbe_cpu_model.sv ====
// Purpose: CPU software model that drives the register port
// Assumes: Caller waits out the stall before its next call
// Notes: Interrupts count as already off, so keys go back to back
`timescale 1ns/1ns
`default_nettype none
module fbe_cpu_model (
  input wire logic i_clk,
  output logic [2:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_wr,
  output logic o_rd
);
  initial {o_addr, o_wdata, o_wr, o_rd} = '0;
  // Strobe stays up for back-to-back accesses; idle drops it
  task automatic acc(input logic [2:0] a, input logic [7:0] d, input logic w);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= w;
    o_rd <= !w;
    @(posedge i_clk);
  endtask
  task automatic idle();
    o_wr <= 1'b0;
    o_rd <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic seq(input logic [21:0] p, input logic [7:0] c, k1, k2);
    acc(3'h0, p[7:0], 1'b1);
    acc(3'h1, p[15:8], 1'b1);
    acc(3'h2, {2'b00, p[21:16]}, 1'b1);
    acc(3'h3, c & 8'hFD, 1'b1);
    acc(3'h4, k1, 1'b1);
    acc(3'h4, k2, 1'b1);
    acc(3'h3, c, 1'b1);
    idle();
  endtask
endmodule
`default_nettype wire

// ==== sim/fbe_sequencer_checker.sv ====
// Purpose: Port-level assertions for the erase sequencer
// Assumes: Reset is held for more than one edge
// Notes: Reads are not tracked as they never break the unlock
`timescale 1ns/1ns
`default_nettype none
module fbe_sequencer_checker
  import fbe_pkg::*;
#(
  parameter int ERASE_CYCLES_P = ERASE_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic o_cpu_stall,
  input wire logic o_erase_start,
  input wire logic o_erase_done,
  input wire logic [BLOCK_W-1:0] o_erase_block
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  logic [15:0] cnt_reg;
  logic k1_reg, k2_reg;
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      {cnt_reg, k1_reg, k2_reg} <= '0;
    end else begin
      cnt_reg <= o_cpu_stall ? cnt_reg + 16'h0001 : 16'h0000;
      if (i_wr) begin
        k1_reg <= i_addr == 3'h4 && i_wdata == 8'h55;
        k2_reg <= k1_reg && i_addr == 3'h4 && i_wdata == 8'hAA;
      end
    end
  end
  a_start_rise: assert property (o_erase_start |-> $rose(o_cpu_stall)) else $error("start without stall");
  a_rise_start: assert property ($rose(o_cpu_stall) |-> o_erase_start) else $error("stall without start");
  a_start_cause: assert property ($rose(o_cpu_stall) |-> $past(i_wr && i_addr == 3'h3 && i_wdata[1]))
    else $error("erase without start write");
  a_mem_select: assert property ($rose(o_cpu_stall) |-> $past(i_wdata[7:6]) == 2'b10) else $error("bad space");
  a_erase_sel: assert property ($rose(o_cpu_stall) |-> $past(i_wdata[4])) else $error("erase not selected");
  a_write_enable_bit_need: assert property ($rose(o_cpu_stall) |-> $past(i_wdata[2])) else $error("write not enabled");
  a_key_order: assert property ($rose(o_cpu_stall) |-> $past(k2_reg)) else $error("erase without unlock");
  a_stall_len: assert property ($fell(o_cpu_stall) && !$past(i_reset) |-> cnt_reg == 16'(ERASE_CYCLES_P + 2))
    else $error("stall length wrong");
  a_done_end: assert property ($fell(o_cpu_stall) && !$past(i_reset) |-> o_erase_done) else $error("no done");
  a_done_only: assert property (o_erase_done |-> $fell(o_cpu_stall)) else $error("stray done");
  a_block_hold: assert property (!o_erase_start && !$past(i_reset) |-> $stable(o_erase_block))
    else $error("block moved");
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00) else $error("read data outside slot");
  c_start: cover property (o_erase_start);
  c_done: cover property (o_erase_done);
  c_reject: cover property (i_wr && i_addr == 3'h3 && i_wdata[1] ##1 !o_cpu_stall);
endmodule
bind fbe_sequencer fbe_sequencer_checker #(.ERASE_CYCLES_P(ERASE_CYCLES_P)) u_chk (.*);
`default_nettype wire

// ==== sim/tb_top.sv ====
// Purpose: Self-checking bench for the erase sequencer
// Assumes: Erase shortened to 8 cycles
// Notes: Results are matched in order against one queue
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [2:0] addr;
  logic [7:0] wdata, o_rdata;
  logic wr, rd, o_cpu_stall, o_erase_start, o_erase_done, rd_q = 1'b0;
  logic [15:0] blk;
  logic [21:0] p;
  logic [16:0] q[$];
  int mismatches = 0, check_count = 0, cyc = 0;
  always #25 i_clk = ~i_clk;
  fbe_cpu_model u_cpu (.i_clk(i_clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
  fbe_sequencer #(.ERASE_CYCLES_P(8)) uut (.i_clk(i_clk), .i_reset(i_reset), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(o_rdata), .o_cpu_stall(o_cpu_stall),
    .o_erase_start(o_erase_start), .o_erase_done(o_erase_done), .o_erase_block(blk));
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [16:0] v);
    logic [16:0] e;
    e = q.size() > 0 ? q.pop_front() : 17'h1_FFFF;
    check_count++;
    if (v !== e) begin
      mismatches++;
      $display("[ERR] result exp %h got %h", e, v);
    end
  endtask
  // Registered outputs, so the pre-edge value is the settled one
  always @(posedge i_clk) begin
    if (rd_q) chk({9'h000, o_rdata});
    if (o_erase_start) chk({1'b1, blk});
    rd_q <= rd;
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      wrap_up();
    end
  end
  task automatic rd_exp(input logic [2:0] a, input logic [7:0] e);
    q.push_back({9'h000, e});
    u_cpu.acc(a, 8'h00, 1'b0);
    u_cpu.idle();
  endtask
  task automatic erase(input logic [7:0] c, k1, k2, input logic ok);
    p = 22'($urandom);
    if (ok) q.push_back({1'b1, p[21:6]});
    u_cpu.seq(p, c, k1, k2);
    for (int i = 0; ok && i < 20 && o_erase_done !== 1'b1; i++) @(posedge i_clk);
    rd_exp(3'h3, (c & 8'hD4) | (ok ? 8'h00 : 8'h08));
  endtask
  initial begin
    void'($urandom(10873));
    repeat (12) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    rd_exp(3'h3, 8'h00);
    rd_exp(3'h5, 8'h00);
    erase(8'h96, 8'h55, 8'hAA, 1'b1);
    rd_exp(3'h2, {2'b00, p[21:16]});
    rd_exp(3'h4, 8'h00);
    erase(8'hD6, 8'h55, 8'hAA, 1'b0);
    erase(8'h16, 8'h55, 8'hAA, 1'b0);
    erase(8'h86, 8'h55, 8'hAA, 1'b0);
    erase(8'h92, 8'h55, 8'hAA, 1'b0);
    erase(8'h96, 8'hAA, 8'h55, 1'b0);
    erase(8'h96, 8'h55, 8'hA5, 1'b0);
    erase(8'hB7, 8'h55, 8'hAA, 1'b1);
    wrap_up();
  end
endmodule
`default_nettype wire

// ==== verilog/fbe_pkg.sv ====
// Purpose: Constants and types for the flash block erase sequencer
// Assumes: 20 MHz system clock, 8-bit register port
// Notes: Register offsets and control bit positions are local choices
// How it works
// - Erase needs program memory selected and configuration space deselected.
// - The erase select bit must be set; otherwise no erase happens.
// - Setting write start after a good unlock launches the block erase.
// - CPU stays stalled for the whole timed erase, about 2 ms.
// - Write enable must be set; start is rejected while it is clear.
// - One 64-byte block, pointer bits 21 to 6; low six bits ignored.
// - Instruction execution halts until the internal timer ends the write.
package fbe_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int ERASE_TIME_NS = 2_000_000;
  // Longest time, so rounded down
  localparam int ERASE_CYCLES = ERASE_TIME_NS / CLK_PERIOD_NS;
  localparam int TMR_W = 16;
  localparam int POINTER_W = 22;
  localparam int BLOCK_LSB = 6;
  localparam int BLOCK_W = POINTER_W - BLOCK_LSB;

  localparam logic [2:0] ADDR_POINTER_LOW = 3'h0;
  localparam logic [2:0] ADDR_POINTER_HIGH = 3'h1;
  localparam logic [2:0] ADDR_POINTER_UPPER = 3'h2;
  localparam logic [2:0] ADDR_FLASH_CONTROL = 3'h3;
  localparam logic [2:0] ADDR_UNLOCK_KEY = 3'h4;

  localparam logic [7:0] UNLOCK_KEY_FIRST = 8'h55;
  localparam logic [7:0] UNLOCK_KEY_SECOND = 8'hAA;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] READ_IDLE = 8'h00;

  localparam int BIT_PGM_SEL = 7;
  localparam int BIT_CFG_SEL = 6;
  localparam int BIT_ERASE_SEL = 4;
  localparam int BIT_REJECT = 3;
  localparam int BIT_WRITE_ENABLE = 2;
  localparam int BIT_START = 1;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_KEY1  = 4'b0010,
    ST_ARMED = 4'b0100,
    ST_ERASE = 4'b1000
  } fbe_state_t;
endpackage

// ==== verilog/fbe_sequencer.sv ====
// Purpose: Self-timed block erase of program flash under software control
// Assumes: Register writes come from the CPU; no bus writes arrive while it is stalled
// Notes: Reads do not break the unlock sequence; any other write does
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module fbe_sequencer
  import fbe_pkg::*;
#(
  parameter int ERASE_CYCLES_P = ERASE_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic o_cpu_stall,
  output logic o_erase_start,
  output logic o_erase_done,
  output logic [BLOCK_W-1:0] o_erase_block
);
  typedef struct packed {
    fbe_state_t state;
    logic [POINTER_W-1:0] table_pointer;
    logic pgm_sel;
    logic cfg_sel;
    logic erase_sel;
    logic write_enable;
    logic start;
    logic reject;
    logic [7:0] rdata;
    logic stall;
    logic erase_start;
    logic erase_done;
    logic [BLOCK_W-1:0] block;
  } fbe_seq_t;

  fbe_seq_t r_reg;
  fbe_seq_t r_next;
  logic timer_done;
  logic launch_ok;

  function automatic logic [7:0] ctrl_byte(input fbe_seq_t s);
    logic [7:0] b;
    b = CTRL_RESET;
    b[BIT_PGM_SEL] = s.pgm_sel;
    b[BIT_CFG_SEL] = s.cfg_sel;
    b[BIT_ERASE_SEL] = s.erase_sel;
    b[BIT_REJECT] = s.reject;
    b[BIT_WRITE_ENABLE] = s.write_enable;
    b[BIT_START] = s.start;
    return b;
  endfunction

  // Bits as written in the same cycle as the start request decide the launch
  assign launch_ok = (r_reg.state == ST_ARMED)
                     && i_wdata[BIT_WRITE_ENABLE]
                     && i_wdata[BIT_PGM_SEL]
                     && !i_wdata[BIT_CFG_SEL]
                     && i_wdata[BIT_ERASE_SEL];

  always_comb begin
    r_next = r_reg;
    r_next.erase_start = 1'b0;
    r_next.erase_done = 1'b0;
    r_next.rdata = READ_IDLE;
    if (i_rd) begin
      unique case (i_addr)
        ADDR_POINTER_LOW: r_next.rdata = r_reg.table_pointer[7:0];
        ADDR_POINTER_HIGH: r_next.rdata = r_reg.table_pointer[15:8];
        ADDR_POINTER_UPPER: r_next.rdata = {2'b00, r_reg.table_pointer[21:16]};
        ADDR_FLASH_CONTROL: r_next.rdata = ctrl_byte(r_reg);
        // Key port and unmapped addresses read as zero
        default: r_next.rdata = READ_IDLE;
      endcase
    end
    unique case (r_reg.state)
      ST_IDLE, ST_KEY1, ST_ARMED: begin
        if (i_wr) begin
          // Any write that is not the next key byte drops the unlock
          r_next.state = ST_IDLE;
          unique case (i_addr)
            ADDR_POINTER_LOW: r_next.table_pointer[7:0] = i_wdata;
            ADDR_POINTER_HIGH: r_next.table_pointer[15:8] = i_wdata;
            ADDR_POINTER_UPPER: r_next.table_pointer[21:16] = i_wdata[5:0];
            ADDR_UNLOCK_KEY: begin
              if (i_wdata == UNLOCK_KEY_FIRST) begin
                r_next.state = ST_KEY1;
              end else if (i_wdata == UNLOCK_KEY_SECOND && r_reg.state == ST_KEY1) begin
                r_next.state = ST_ARMED;
              end
            end
            ADDR_FLASH_CONTROL: begin
              r_next.pgm_sel = i_wdata[BIT_PGM_SEL];
              r_next.cfg_sel = i_wdata[BIT_CFG_SEL];
              r_next.erase_sel = i_wdata[BIT_ERASE_SEL];
              r_next.write_enable = i_wdata[BIT_WRITE_ENABLE];
              // Set wins over a clear written in the same cycle
              r_next.reject = i_wdata[BIT_REJECT] && r_reg.reject;
              if (i_wdata[BIT_START]) begin
                if (launch_ok) begin
                  r_next.state = ST_ERASE;
                  r_next.start = 1'b1;
                  r_next.stall = 1'b1;
                  r_next.erase_start = 1'b1;
                  r_next.block = r_reg.table_pointer[POINTER_W-1:BLOCK_LSB];
                end else begin
                  r_next.reject = 1'b1;
                end
              end
            end
            default: r_next.state = ST_IDLE;
          endcase
        end
      end
      ST_ERASE: begin
        // CPU is stalled; stray writes are dropped until the timer ends
        if (timer_done) begin
          r_next.state = ST_IDLE;
          r_next.start = 1'b0;
          r_next.stall = 1'b0;
          r_next.erase_done = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      r_reg <= '0;
      r_reg.state <= ST_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  fbe_timer #(
    .CYCLES(ERASE_CYCLES_P)
  ) u_timer (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_start(r_reg.erase_start),
    .o_done(timer_done)
  );

  assign o_rdata = r_reg.rdata;
  assign o_cpu_stall = r_reg.stall;
  assign o_erase_start = r_reg.erase_start;
  assign o_erase_done = r_reg.erase_done;
  assign o_erase_block = r_reg.block;
endmodule
`default_nettype wire

// ==== verilog/fbe_timer.sv ====
// Purpose: Erase duration timer, one done pulse per start
// Assumes: Start is a one-cycle pulse, not repeated while running
// Notes: Done comes CYCLES edges after the start is seen
`timescale 1ns/1ns
`default_nettype none
module fbe_timer
  import fbe_pkg::*;
#(
  parameter int CYCLES = ERASE_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_start,
  output logic o_done
);
  typedef struct packed {
    logic [TMR_W-1:0] count;
    logic run;
    logic done;
  } fbe_tmr_t;

  fbe_tmr_t r_reg;
  fbe_tmr_t r_next;

  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    if (i_start) begin
      r_next.count = TMR_W'(CYCLES - 1);
      r_next.run = 1'b1;
    end else if (r_reg.run) begin
      if (r_reg.count == '0) begin
        r_next.run = 1'b0;
        r_next.done = 1'b1;
      end else begin
        r_next.count = r_reg.count - 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_done = r_reg.done;
endmodule
`default_nettype wire
